// [tcc_pkg.sv]
// constants, register map, mode and interrupt source types for the timer/capture block
// assumes an 8-bit register port and one 50 MHz system clock
package tcc_pkg;

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [3:0] REG_CNT_HI   = 4'h0;
  localparam logic [3:0] REG_CNT_LO   = 4'h1;
  localparam logic [3:0] REG_RLD_HI   = 4'h2;
  localparam logic [3:0] REG_RLD_LO   = 4'h3;
  localparam logic [3:0] REG_CAP_HI   = 4'h4;
  localparam logic [3:0] REG_CAP_LO   = 4'h5;
  localparam logic [3:0] REG_CTL      = 4'h6;
  localparam logic [3:0] REG_CTL2     = 4'h7;

  // ----------------------------------------
  // main control fields
  // ----------------------------------------
  localparam int CTL_EN_BIT   = 7;
  localparam int CTL_POL_BIT  = 6;
  localparam int CTL_PRE_LSB  = 3;
  localparam int CTL_MODE_LSB = 0;

  // ----------------------------------------
  // second control fields
  // ----------------------------------------
  localparam int CTL2_MHI_BIT  = 7;
  localparam int CTL2_ISRC_LSB = 5;
  localparam int CTL2_FLAG_BIT = 4;
  localparam int CTL2_OEN_BIT  = 0;

  // ----------------------------------------
  // values
  // ----------------------------------------
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] RLD_RST     = 16'hffff;
  localparam logic [7:0]  RD_ZERO     = 8'h00;

  // ----------------------------------------
  // modes, {mode_high_bit, mode}
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_CONTINUOUS = 4'b0001,
    MODE_CAPTURE    = 4'b0100,
    MODE_CMP_COUNT  = 4'b0110,
    MODE_CAP_RESTART = 4'b1000
  } tcc_mode_t;

  // interrupt_source_select codes
  typedef enum logic [1:0] {
    ISRC_BOTH    = 2'b00,
    ISRC_BOTH_B  = 2'b01,
    ISRC_CAPTURE = 2'b10,
    ISRC_RELOAD  = 2'b11
  } tcc_isrc_t;

endpackage : tcc_pkg

// [tcc_edge.sv]
// two-stage synchroniser with rising and falling edge pulses
// assumes an asynchronous input and one system clock
`timescale 1ns/1ns
`default_nettype none
module tcc_edge
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // pin side
  input  wire logic sig_i,
  // edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } tcc_edge_st_t;

  tcc_edge_st_t q;
  tcc_edge_st_t next_q;

  // first stage feeds only the second
  always_comb begin
    next_q      = q;
    next_q.s1   = sig_i;
    next_q.s2   = q.s1;
    next_q.prev = q.s2;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rise_o = q.s2 & ~q.prev;
  assign fall_o = ~q.s2 & q.prev;

endmodule : tcc_edge
`default_nettype wire

// [tcc_prescale.sv]
// power-of-two prescaler giving a one-cycle enable pulse
// assumes run_i low while the timer is disabled
`timescale 1ns/1ns
`default_nettype none
module tcc_prescale
  import tcc_pkg::*;
#(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // control
  input  wire logic         run_i,
  input  wire logic [2:0]   shift_i,
  // tick
  output logic              tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tcc_pre_st_t;

  tcc_pre_st_t  q;
  tcc_pre_st_t  next_q;
  logic [W-1:0] mask;

  assign mask   = W'((1 << shift_i) - 1);
  assign tick_o = run_i && ((q.cnt & mask) == mask);

  // restart from zero when stopped so the first pass is full length
  always_comb begin
    next_q = q;
    if (!run_i) begin
      next_q.cnt = '0;
    end else begin
      next_q.cnt = W'(q.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule : tcc_prescale
`default_nettype wire

// [tcc_timer.sv]
// 16-bit timer: comparator counter, capture and capture restart
// assumes an 8-bit register port with read data one cycle later
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int PRE_W = 7
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // comparator and timer pins
  input  wire logic       comp_i,
  input  wire logic       tin_i,
  output logic            tout_o,
  output logic            tout_en_o,
  // interrupt request
  output logic            irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] capture;
    logic        en;
    logic        pol;
    logic [2:0]  presc;
    logic [2:0]  mode;
    logic        mode_hi;
    logic [1:0]  isrc;
    logic        flag;
    logic        oen;
    logic        tout;
    logic [7:0]  rdata;
    logic        irq;
  } tcc_st_t;

  tcc_st_t q;
  tcc_st_t next_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic sel_edge(input logic pol, input logic r, input logic f);
    return pol ? f : r;
  endfunction : sel_edge

  function automatic logic [7:0] hi_b(input logic [15:0] v);
    return v[15:8];
  endfunction : hi_b

  logic      cmp_rise;
  logic      cmp_fall;
  logic      pin_rise;
  logic      pin_fall;
  logic      tick;
  tcc_mode_t fmode;
  logic      is_cc;
  logic      is_cap;
  logic      is_rst;
  logic      step;
  logic      cap_evt;
  logic      at_reload;
  logic      cap_irq;
  logic      rl_irq;
  logic      wr_cnt;

  tcc_edge u_cmp_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .sig_i   (comp_i),
    .rise_o  (cmp_rise),
    .fall_o  (cmp_fall)
  );

  tcc_edge u_pin_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .sig_i   (tin_i),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  tcc_prescale #(
    .W (PRE_W)
  ) u_pre (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (q.en),
    .shift_i (q.presc),
    .tick_o  (tick)
  );

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  assign fmode  = tcc_mode_t'({q.mode_hi, q.mode});
  assign is_cc  = (fmode == MODE_CMP_COUNT);
  assign is_cap = (fmode == MODE_CAPTURE);
  assign is_rst = (fmode == MODE_CAP_RESTART);
  // comparator mode counts edges, others count prescaled clock
  assign step      = q.en && (is_cc ? sel_edge(q.pol, cmp_rise, cmp_fall) : tick);
  assign cap_evt   = q.en && (is_cap || is_rst)
                     && sel_edge(q.pol, pin_rise, pin_fall);
  assign at_reload = step && (q.count == q.reload);
  // only plain capture mode may mask the capture interrupt; restart always raises it
  assign cap_irq   = cap_evt && !(is_cap && q.isrc == ISRC_RELOAD);
  // a restart capture in the same cycle supersedes the reload
  assign rl_irq    = at_reload && !(cap_evt && is_rst)
                     && !(is_cap && q.isrc == ISRC_CAPTURE);
  assign wr_cnt    = wr_i && (addr_i == REG_CNT_HI || addr_i == REG_CNT_LO);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_q       = q;
    next_q.irq   = 1'b0;
    next_q.rdata = RD_ZERO;
    // initial output level follows edge select while stopped
    if (!q.en) begin
      next_q.tout = q.pol;
    end
    if (step) begin
      next_q.count = 16'(q.count + 1'b1);
    end
    if (at_reload) begin
      next_q.count = CNT_RESTART;
      if (q.oen) begin
        next_q.tout = ~q.tout;
      end
      if (is_cap || is_rst) begin
        next_q.flag = 1'b0;
      end
    end
    // capture set wins over a reload clear
    if (cap_evt) begin
      next_q.capture = q.count;
      next_q.flag    = 1'b1;
      if (is_rst) begin
        next_q.count = CNT_RESTART;
      end
    end
    next_q.irq = cap_irq || rl_irq;
    // bus writes take priority over counting
    if (wr_i) begin
      case (addr_i)
        REG_CNT_HI: begin
          next_q.count[15:8] = wdata_i;
        end
        REG_CNT_LO: begin
          next_q.count[7:0] = wdata_i;
        end
        REG_RLD_HI: begin
          next_q.reload[15:8] = wdata_i;
        end
        REG_RLD_LO: begin
          next_q.reload[7:0] = wdata_i;
        end
        REG_CTL: begin
          next_q.en    = wdata_i[CTL_EN_BIT];
          next_q.pol   = wdata_i[CTL_POL_BIT];
          next_q.presc = wdata_i[CTL_PRE_LSB +: 3];
          next_q.mode  = wdata_i[CTL_MODE_LSB +: 3];
        end
        REG_CTL2: begin
          next_q.mode_hi = wdata_i[CTL2_MHI_BIT];
          next_q.isrc    = wdata_i[CTL2_ISRC_LSB +: 2];
          next_q.oen     = wdata_i[CTL2_OEN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        REG_CNT_HI: next_q.rdata = hi_b(q.count);
        REG_CNT_LO: next_q.rdata = q.count[7:0];
        REG_RLD_HI: next_q.rdata = hi_b(q.reload);
        REG_RLD_LO: next_q.rdata = q.reload[7:0];
        REG_CAP_HI: next_q.rdata = hi_b(q.capture);
        REG_CAP_LO: next_q.rdata = q.capture[7:0];
        REG_CTL: begin
          next_q.rdata[CTL_EN_BIT]          = q.en;
          next_q.rdata[CTL_POL_BIT]         = q.pol;
          next_q.rdata[CTL_PRE_LSB +: 3]    = q.presc;
          next_q.rdata[CTL_MODE_LSB +: 3]   = q.mode;
        end
        REG_CTL2: begin
          next_q.rdata[CTL2_MHI_BIT]        = q.mode_hi;
          next_q.rdata[CTL2_ISRC_LSB +: 2]  = q.isrc;
          next_q.rdata[CTL2_FLAG_BIT]       = q.flag;
          next_q.rdata[CTL2_OEN_BIT]        = q.oen;
        end
        default: next_q.rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q        <= '0;
      q.count  <= CNT_RST;
      q.reload <= RLD_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_o   = q.rdata;
  assign tout_o    = q.tout;
  assign tout_en_o = q.oen;
  assign irq_o     = q.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_cc_reload;
    @(posedge clk_i) disable iff (!rst_b_i)
    (is_cc && at_reload && !wr_i) |=> (q.count == CNT_RESTART) && irq_o;
  endproperty
  a_cc_reload: assert property (p_cc_reload) else $error("no restart at reload");

  property p_tout_toggle;
    @(posedge clk_i) disable iff (!rst_b_i)
    (at_reload && q.oen && q.en) |=> (tout_o != $past(tout_o));
  endproperty
  a_tout_toggle: assert property (p_tout_toggle) else $error("output did not toggle");

  property p_init_level;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!q.en) |=> (tout_o == $past(q.pol));
  endproperty
  a_init_level: assert property (p_init_level) else $error("wrong initial level");

  property p_cc_inc;
    @(posedge clk_i) disable iff (!rst_b_i)
    (step && is_cc && !at_reload && !wr_cnt) |=> (q.count == 16'($past(q.count) + 1'b1));
  endproperty
  a_cc_inc: assert property (p_cc_inc) else $error("count step not one");

  property p_cap_copy;
    @(posedge clk_i) disable iff (!rst_b_i)
    cap_evt |=> (q.capture == $past(q.count));
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture value wrong");

  property p_rst_restart;
    @(posedge clk_i) disable iff (!rst_b_i)
    (cap_evt && is_rst && !wr_cnt) |=> (q.count == CNT_RESTART) && irq_o;
  endproperty
  a_rst_restart: assert property (p_rst_restart) else $error("no restart on capture");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    cap_evt |=> q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
    (at_reload && is_rst && !cap_evt) |=> !q.flag && irq_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_frozen;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!q.en && !wr_cnt) |=> $stable(q.count);
  endproperty
  a_frozen: assert property (p_frozen) else $error("count moved while off");

  property p_src_reload_only;
    @(posedge clk_i) disable iff (!rst_b_i)
    (is_cap && q.isrc == ISRC_RELOAD && cap_evt && !at_reload) |=> !irq_o;
  endproperty
  a_src_reload_only: assert property (p_src_reload_only) else $error("capture irq not masked");

  property p_src_capture_only;
    @(posedge clk_i) disable iff (!rst_b_i)
    (is_cap && q.isrc == ISRC_CAPTURE && at_reload && !cap_evt) |=> !irq_o;
  endproperty
  a_src_capture_only: assert property (p_src_capture_only) else $error("reload irq not masked");

  property p_rst_reload;
    @(posedge clk_i) disable iff (!rst_b_i)
    (at_reload && is_rst && !cap_evt && !wr_cnt) |=> (q.count == CNT_RESTART);
  endproperty
  a_rst_reload: assert property (p_rst_reload) else $error("no restart at reload value");

  property p_presc_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    (is_cap && !tick && !wr_cnt) |=> $stable(q.count);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("count moved between ticks");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (!rst_b_i)
    !rd_i |=> (rdata_o == RD_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  c_cc_reload: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_cc && at_reload);
  c_rst_cap:   cover property (@(posedge clk_i) disable iff (!rst_b_i) is_rst && cap_evt);
  c_rst_rld:   cover property (@(posedge clk_i) disable iff (!rst_b_i) is_rst && at_reload);
  c_rst_fall:  cover property (@(posedge clk_i) disable iff (!rst_b_i) is_rst && cap_evt && q.pol);

endmodule : tcc_timer
`default_nettype wire

// [tcc_pin_model.sv]
// far-side model: comparator output and timer input pin
// assumes the system clock of the timer; lines change just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
  // clock
  input  wire logic clk_i,
  // pins toward the timer
  output logic      comp_o,
  output logic      tin_o
);
  initial begin
    comp_o = 1'b0;
    tin_o  = 1'b0;
  end

  // n full comparator cycles; half of at least 2 keeps the rate at clk/4 or below
  task automatic comp_edges(input int n, input int half);
    repeat (2 * n) begin
      repeat (half) @(posedge clk_i);
      comp_o <= ~comp_o;
    end
  endtask : comp_edges

  // one input level change after a quiet gap
  task automatic tin_edge(input int gap);
    repeat (gap) @(posedge clk_i);
    tin_o <= ~tin_o;
  endtask : tin_edge

  // high pulse of 4 cycles after a quiet gap
  task automatic tin_pulse(input int gap);
    tin_edge(gap);
    tin_edge(4);
  endtask : tin_pulse
endmodule : tcc_pin_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the timer/capture block
// assumes the register map of the package and the pin model beside it
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tcc_pkg::*;

  logic        clk_i;
  logic        rst_b_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        comp_i;
  logic        tin_i;
  logic        tout_o;
  logic        tout_en_o;
  logic        irq_o;
  int          irq_cnt = 0;
  int          num_errors;
  int          total_checks;

  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  tcc_timer #(.PRE_W(7)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_i(comp_i), .tin_i(tin_i),
    .tout_o(tout_o), .tout_en_o(tout_en_o), .irq_o(irq_o)
  );
  tcc_pin_model pins (.clk_i(clk_i), .comp_o(comp_i), .tin_o(tin_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // irq is a one-cycle pulse, so count every one
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 4'h1, l);
    v = {h, l};
  endtask : rd16

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    logic [15:0] v1;
    logic [7:0]  b;
    int          n0;
    int          n1;
    int          n2;
    rst_b_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0;
    num_errors = 0; total_checks = 0;
    cyc(4);
    rst_b_i <= 1'b1;
    // reset values, byte access, unmapped index
    rd16(REG_CNT_HI, v); chk(v, 16'h0000);
    rd16(REG_RLD_HI, v); chk(v, 16'hffff);
    wr(REG_RLD_HI, 8'h12); wr(REG_RLD_LO, 8'h34); wr(4'ha, 8'h5a);
    rd16(REG_RLD_HI, v); chk(v, 16'h1234);
    rd(4'ha, b); chk({8'h00, b}, 16'h0000);
    // comparator counter, start 0002, reload 0004, output enabled
    wr(REG_CTL, 8'h00); wr(REG_CTL2, 8'h01);
    wr(REG_CNT_HI, 8'h00); wr(REG_CNT_LO, 8'h02); wr(REG_RLD_HI, 8'h00); wr(REG_RLD_LO, 8'h04);
    #1 chk({15'h0, tout_o}, 16'h0000);
    chk({15'h0, tout_en_o}, 16'h0001);
    n0 = irq_cnt;
    wr(REG_CTL, 8'h86);
    pins.comp_edges(3, 3); cyc(8);
    chk(16'(irq_cnt - n0), 16'h0001);
    chk({15'h0, tout_o}, 16'h0001);
    rd16(REG_CNT_HI, v); chk(v, 16'h0001);
    pins.comp_edges(2, 3); cyc(8);
    rd16(REG_CNT_HI, v); chk(v, 16'h0003);
    pins.comp_edges(2, 3); cyc(8);
    chk(16'(irq_cnt - n0), 16'h0002);
    chk({15'h0, tout_o}, 16'h0000);
    rd16(REG_CNT_HI, v); chk(v, 16'h0001);
    // frozen while disabled, then falling edges with the other polarity
    wr(REG_CTL, 8'h06);
    pins.comp_edges(2, 3); cyc(8);
    rd16(REG_CNT_HI, v); chk(v, 16'h0001);
    wr(REG_CTL, 8'h46); cyc(1);
    #1 chk({15'h0, tout_o}, 16'h0001);
    wr(REG_CTL, 8'hc6);
    pins.comp_edges(1, 3); cyc(8);
    rd16(REG_CNT_HI, v); chk(v, 16'h0002);
    // capture mode, prescale 2: each source select code, capture then reload
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTL, 8'h00); wr(REG_CTL2, 8'(k << CTL2_ISRC_LSB));
      wr(REG_CNT_HI, 8'h00); wr(REG_CNT_LO, 8'h01); wr(REG_RLD_HI, 8'h00); wr(REG_RLD_LO, 8'h10);
      n0 = irq_cnt;
      wr(REG_CTL, 8'h8c);
      pins.tin_pulse(1); cyc(6);
      n1 = irq_cnt;
      cyc(40);
      n2 = irq_cnt;
      chk({15'h0, n1 != n0}, {15'h0, k != 3});
      chk({15'h0, n2 != n1}, {15'h0, k != 2});
    end
    // capture restart, reload 0040, one clock per step
    wr(REG_CTL, 8'h00); wr(REG_CTL2, 8'h80);
    wr(REG_CNT_HI, 8'h00); wr(REG_CNT_LO, 8'h01); wr(REG_RLD_HI, 8'h00); wr(REG_RLD_LO, 8'h40);
    wr(REG_CTL, 8'h80);
    n0 = irq_cnt;
    pins.tin_pulse(2); pins.tin_pulse(20); cyc(6);
    chk(16'(irq_cnt - n0), 16'h0002);
    rd(REG_CTL2, b); chk({15'h0, b[CTL2_FLAG_BIT]}, 16'h0001);
    rd16(REG_CAP_HI, v1);
    pins.tin_pulse(2); pins.tin_pulse(36); cyc(6);
    rd16(REG_CAP_HI, v);
    // offset of the capture pipeline cancels in the difference
    chk(v - v1, 16'h0010);
    n1 = irq_cnt;
    cyc(80);
    chk({15'h0, irq_cnt != n1}, 16'h0001);
    rd(REG_CTL2, b); chk({15'h0, b[CTL2_FLAG_BIT]}, 16'h0000);
    wr(REG_CTL, 8'h00);
    rd16(REG_CNT_HI, v); chk({15'h0, v >= 16'h0001 && v <= 16'h0040}, 16'h0001);
    // falling input edges only, from a fresh start at 0001
    wr(REG_CTL, 8'h40); wr(REG_CNT_HI, 8'h00); wr(REG_CNT_LO, 8'h01); wr(REG_CTL, 8'hc0);
    n1 = irq_cnt;
    pins.tin_edge(2); cyc(8);
    chk(16'(irq_cnt - n1), 16'h0000);
    pins.tin_edge(2); cyc(8);
    chk(16'(irq_cnt - n1), 16'h0001);
    rd(REG_CTL2, b); chk({15'h0, b[CTL2_FLAG_BIT]}, 16'h0001);
    // reset in mid-run: control and reload back to their reset values
    cyc(1); rst_b_i <= 1'b0; cyc(3); rst_b_i <= 1'b1;
    rd(REG_CTL, b); chk({8'h00, b}, 16'h0000);
    rd16(REG_RLD_HI, v); chk(v, 16'hffff);
    give_verdict();
  end

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
